// ---- abx_defines.svh ----
`ifndef ABX_DEFINES_SVH
`define ABX_DEFINES_SVH
`define ABX_OFF_ACC 32'h0000_0000
`define ABX_OFF_STATUS 32'h0000_0004
`define ABX_OFF_CTRL 32'h0000_0008
`define ABX_OFF_EXEC 32'h0000_000c
`define ABX_ST_C 0
`define ABX_ST_DC 1
`define ABX_ST_Z 2
`define ABX_CTRL_RUN 0
`define ABX_EXEC_SKIP 0
`define ABX_EXEC_BUSY 1
`define ABX_EXEC_CNT_LSB 16
`define ABX_EXEC_CNT_MSB 31
`define ABX_CTRL_RST 1'b0
`define ABX_ACC_RST 8'h00
`define ABX_CNT_RST 16'h0000
`endif

// ---- abx_pkg.sv ----
package abx_pkg;
  typedef enum logic [3:0] {
    ABX_NOP,
    ABX_ADD_LITERAL_TO_ACC,
    ABX_ADD_ACC_AND_FILE,
    ABX_AND_LITERAL_WITH_ACC,
    ABX_AND_ACC_WITH_FILE,
    ABX_FILE_BIT_CLEAR,
    ABX_FILE_BIT_SET,
    ABX_TEST_BIT_SKIP_IF_ONE,
    ABX_TEST_BIT_SKIP_IF_ZERO
  } abx_op_t;
  typedef enum logic [1:0] {
    ABX_Q1,
    ABX_Q2,
    ABX_Q3,
    ABX_Q4
  } abx_phase_t;
endpackage

// ---- abx_execute.sv ----
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "abx_defines.svh"
module abx_execute (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  output logic instr_ready,
  input abx_pkg::abx_op_t instr_op,
  input wire logic [7:0] instr_lit,
  input wire logic [6:0] instr_faddr,
  input wire logic [2:0] instr_bit,
  input wire logic instr_dest,
  output logic [6:0] file_addr,
  input wire logic [7:0] file_rd_data,
  input wire logic port_hit,
  input wire logic [7:0] port_pins,
  output logic file_we,
  output logic [7:0] file_wr_data,
  output logic [7:0] acc,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic skip_nop
);
  // instruction cycle phases
  abx_pkg::abx_phase_t phase_q, phase_d;
  // latched instruction
  abx_pkg::abx_op_t op_q, op_d;
  logic [7:0] lit_q, lit_d;
  logic [6:0] faddr_q, faddr_d;
  logic [2:0] bit_q, bit_d;
  logic dest_q, dest_d;
  logic busy_q, busy_d;
  // execute results
  logic [7:0] acc_q, acc_d;
  logic c_q, c_d;
  logic dc_q, dc_d;
  logic z_q, z_d;
  logic skip_q, skip_d;
  logic we_q, we_d;
  logic [7:0] wdata_q, wdata_d;
  logic nop_q, nop_d;
  logic run_q, run_d;
  logic [15:0] cnt_q, cnt_d;
  logic [31:0] prdata_q, prdata_d;
  logic err_q, err_d;
  // combinational datapath
  logic [7:0] opnd;
  logic [7:0] src;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] and_res;
  logic [7:0] bit_clr;
  logic [7:0] bit_set;
  logic tested;
  logic take;
  logic apb_wr;
  logic apb_rd;

  assign take = instr_valid && instr_ready;
  assign instr_ready = run_q && (phase_q == abx_pkg::ABX_Q1);
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  // pins, not the output latch, feed port read-modify-write
  assign opnd = port_hit ? port_pins : file_rd_data;
  assign src = (op_q == abx_pkg::ABX_ADD_LITERAL_TO_ACC ||
                op_q == abx_pkg::ABX_AND_LITERAL_WITH_ACC) ? lit_q : opnd;
  assign sum = {1'b0, acc_q} + {1'b0, src};
  assign nib = {1'b0, acc_q[3:0]} + {1'b0, src[3:0]};
  assign and_res = acc_q & src;
  assign tested = opnd[bit_q];

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_bit
      // full byte rewritten, only the selected bit differs
      assign bit_clr[gi] = (bit_q == 3'(gi)) ? 1'b0 : opnd[gi];
      assign bit_set[gi] = (bit_q == 3'(gi)) ? 1'b1 : opnd[gi];
    end
  endgenerate

  // phase sequencer and instruction latch
  always_comb
  begin
    phase_d = phase_q;
    op_d = op_q;
    lit_d = lit_q;
    faddr_d = faddr_q;
    bit_d = bit_q;
    dest_d = dest_q;
    busy_d = busy_q;
    nop_d = 1'b0;
    case (phase_q)
      abx_pkg::ABX_Q1: phase_d = abx_pkg::ABX_Q2;
      abx_pkg::ABX_Q2: phase_d = abx_pkg::ABX_Q3;
      abx_pkg::ABX_Q3: phase_d = abx_pkg::ABX_Q4;
      abx_pkg::ABX_Q4: phase_d = abx_pkg::ABX_Q1;
      default: phase_d = abx_pkg::ABX_Q1;
    endcase
    if (phase_q == abx_pkg::ABX_Q4)
    begin
      busy_d = 1'b0;
    end
    if (take)
    begin
      busy_d = 1'b1;
      // a pending skip turns this fetch into a no-operation
      op_d = skip_q ? abx_pkg::ABX_NOP : instr_op;
      nop_d = skip_q;
      lit_d = instr_lit;
      faddr_d = instr_faddr;
      bit_d = instr_bit;
      dest_d = instr_dest;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      phase_q <= abx_pkg::ABX_Q1;
      op_q <= abx_pkg::ABX_NOP;
      lit_q <= `ABX_ACC_RST;
      faddr_q <= 7'h00;
      bit_q <= 3'h0;
      dest_q <= 1'b0;
      busy_q <= 1'b0;
      nop_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      op_q <= op_d;
      lit_q <= lit_d;
      faddr_q <= faddr_d;
      bit_q <= bit_d;
      dest_q <= dest_d;
      busy_q <= busy_d;
      nop_q <= nop_d;
    end
  end

  // execute at the end of Q3, results visible in Q4
  always_comb
  begin
    acc_d = acc_q;
    c_d = c_q;
    dc_d = dc_q;
    z_d = z_q;
    skip_d = skip_q;
    we_d = 1'b0;
    wdata_d = wdata_q;
    cnt_d = cnt_q;
    if (take)
    begin
      skip_d = 1'b0;
    end
    if (busy_q && phase_q == abx_pkg::ABX_Q3)
    begin
      cnt_d = cnt_q + 16'h0001;
      case (op_q)
        abx_pkg::ABX_ADD_LITERAL_TO_ACC:
        begin
          acc_d = sum[7:0];
          c_d = sum[8];
          dc_d = nib[4];
          z_d = (sum[7:0] == 8'h00);
        end
        abx_pkg::ABX_ADD_ACC_AND_FILE:
        begin
          c_d = sum[8];
          dc_d = nib[4];
          z_d = (sum[7:0] == 8'h00);
          if (dest_q)
          begin
            we_d = 1'b1;
            wdata_d = sum[7:0];
          end
          else
          begin
            acc_d = sum[7:0];
          end
        end
        abx_pkg::ABX_AND_LITERAL_WITH_ACC:
        begin
          acc_d = and_res;
          z_d = (and_res == 8'h00);
        end
        abx_pkg::ABX_AND_ACC_WITH_FILE:
        begin
          z_d = (and_res == 8'h00);
          if (dest_q)
          begin
            we_d = 1'b1;
            wdata_d = and_res;
          end
          else
          begin
            acc_d = and_res;
          end
        end
        abx_pkg::ABX_FILE_BIT_CLEAR:
        begin
          we_d = 1'b1;
          wdata_d = bit_clr;
        end
        abx_pkg::ABX_FILE_BIT_SET:
        begin
          we_d = 1'b1;
          wdata_d = bit_set;
        end
        abx_pkg::ABX_TEST_BIT_SKIP_IF_ONE: skip_d = tested;
        abx_pkg::ABX_TEST_BIT_SKIP_IF_ZERO: skip_d = !tested;
        default: skip_d = skip_q;
      endcase
    end
    else if (apb_wr && paddr == `ABX_OFF_ACC)
    begin
      // software access loses to an executing instruction
      acc_d = pwdata[7:0];
    end
    else if (apb_wr && paddr == `ABX_OFF_STATUS)
    begin
      c_d = pwdata[`ABX_ST_C];
      dc_d = pwdata[`ABX_ST_DC];
      z_d = pwdata[`ABX_ST_Z];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      acc_q <= `ABX_ACC_RST;
      c_q <= 1'b0;
      dc_q <= 1'b0;
      z_q <= 1'b0;
      skip_q <= 1'b0;
      we_q <= 1'b0;
      wdata_q <= `ABX_ACC_RST;
      cnt_q <= `ABX_CNT_RST;
    end
    else
    begin
      acc_q <= acc_d;
      c_q <= c_d;
      dc_q <= dc_d;
      z_q <= z_d;
      skip_q <= skip_d;
      we_q <= we_d;
      wdata_q <= wdata_d;
      cnt_q <= cnt_d;
    end
  end

  // apb slave, zero wait states, read data captured in setup
  always_comb
  begin
    run_d = run_q;
    prdata_d = prdata_q;
    err_d = 1'b0;
    if (apb_wr && paddr == `ABX_OFF_CTRL)
    begin
      run_d = pwdata[`ABX_CTRL_RUN];
    end
    if (psel && !penable)
    begin
      prdata_d = 32'h0000_0000;
      case (paddr)
        `ABX_OFF_ACC: prdata_d[7:0] = acc_d;
        `ABX_OFF_STATUS:
        begin
          prdata_d[`ABX_ST_C] = c_d;
          prdata_d[`ABX_ST_DC] = dc_d;
          prdata_d[`ABX_ST_Z] = z_d;
        end
        `ABX_OFF_CTRL: prdata_d[`ABX_CTRL_RUN] = run_q;
        `ABX_OFF_EXEC:
        begin
          prdata_d[`ABX_EXEC_SKIP] = skip_d;
          prdata_d[`ABX_EXEC_BUSY] = busy_d;
          prdata_d[`ABX_EXEC_CNT_MSB:`ABX_EXEC_CNT_LSB] = cnt_d;
        end
        default: err_d = 1'b1;
      endcase
      if (!apb_rd)
      begin
        prdata_d = 32'h0000_0000;
      end
    end
    else if (psel && penable)
    begin
      err_d = err_q;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      run_q <= `ABX_CTRL_RST;
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else
    begin
      run_q <= run_d;
      prdata_q <= prdata_d;
      err_q <= err_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = err_q && psel && penable;
  assign file_addr = faddr_q;
  assign file_we = we_q;
  assign file_wr_data = wdata_q;
  assign acc = acc_q;
  assign carry_flag = c_q;
  assign digit_carry_flag = dc_q;
  assign zero_flag = z_q;
  assign skip_nop = nop_q;
endmodule

// ---- abx_checker.sv ----
`timescale 1ns/100ps
module abx_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input abx_pkg::abx_op_t instr_op,
  input wire logic [7:0] instr_lit,
  input wire logic [2:0] instr_bit,
  input wire logic instr_dest,
  input wire logic [7:0] file_rd_data,
  input wire logic port_hit,
  input wire logic [7:0] port_pins,
  input wire logic file_we,
  input wire logic [7:0] file_wr_data,
  input wire logic [7:0] acc,
  input wire logic carry_flag,
  input wire logic digit_carry_flag,
  input wire logic zero_flag,
  input wire logic skip_nop
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // pins win over the latch on port registers
  wire [7:0] opnd = port_hit ? port_pins : file_rd_data;
  wire take = instr_valid && instr_ready;
  sequence run_s;
    ##1 !skip_nop;
  endsequence
  property add_lit_p;
    logic [8:0] s;
    logic [4:0] h;
    (take && instr_op == abx_pkg::ABX_ADD_LITERAL_TO_ACC, s = {1'h0, acc} + instr_lit,
      h = {1'h0, acc[3:0]} + instr_lit[3:0]) ##0 run_s
      |=> ##1 {carry_flag, acc} == s && digit_carry_flag == h[4]
      && zero_flag == (s[7:0] == 8'h00);
  endproperty
  property and_lit_p;
    logic [7:0] r;
    logic c;
    (take && instr_op == abx_pkg::ABX_AND_LITERAL_WITH_ACC, r = acc & instr_lit, c = carry_flag)
      ##0 run_s |=> ##1 acc == r && zero_flag == (r == 8'h00) && carry_flag == c;
  endproperty
  property add_file_p;
    logic [7:0] a;
    logic [8:0] s;
    logic [4:0] h;
    (take && instr_op == abx_pkg::ABX_ADD_ACC_AND_FILE, a = acc) ##0 run_s
      ##1 (1'h1, s = {1'h0, a} + opnd, h = {1'h0, a[3:0]} + opnd[3:0])
      |=> carry_flag == s[8] && digit_carry_flag == h[4] && zero_flag == (s[7:0] == 8'h00);
  endproperty
  property dest_p;
    logic d;
    (take && instr_op inside {abx_pkg::ABX_ADD_ACC_AND_FILE, abx_pkg::ABX_AND_ACC_WITH_FILE},
      d = instr_dest) ##0 run_s |=> ##1 file_we == d;
  endproperty
  property bit_p;
    logic [2:0] b;
    logic v;
    logic [7:0] f;
    (take && instr_op inside {abx_pkg::ABX_FILE_BIT_CLEAR, abx_pkg::ABX_FILE_BIT_SET},
      b = instr_bit, v = instr_op == abx_pkg::ABX_FILE_BIT_SET) ##0 run_s ##1 (1'h1, f = opnd)
      |=> file_we && file_wr_data == ((f & ~(8'h01 << b)) | ({7'h00, v} << b));
  endproperty
  property skip_p;
    logic [2:0] b;
    logic w;
    logic s;
    (take && instr_op inside {abx_pkg::ABX_TEST_BIT_SKIP_IF_ONE,
      abx_pkg::ABX_TEST_BIT_SKIP_IF_ZERO}, b = instr_bit,
      w = instr_op == abx_pkg::ABX_TEST_BIT_SKIP_IF_ONE) ##0 run_s
      ##1 (1'h1, s = opnd[b] == w) ##2 take |=> skip_nop == s;
  endproperty
  ready_gap_a: assert property (instr_ready |=> !instr_ready [*3])
    else $error("ready gap");
  add_lit_a: assert property (add_lit_p) else $error("add literal");
  and_lit_a: assert property (and_lit_p) else $error("and literal");
  add_file_a: assert property (add_file_p) else $error("add file");
  dest_sel_a: assert property (dest_p) else $error("destination");
  bit_write_a: assert property (bit_p) else $error("bit write");
  skip_sel_a: assert property (skip_p) else $error("skip select");
  nop_quiet_a: assert property (skip_nop |=> ##1 !file_we && $stable(acc))
    else $error("nop");
endmodule
bind abx_execute abx_checker abx_checker_i (.*);

// ---- abx_file_mem.sv ----
`timescale 1ns/100ps
module abx_file_mem #(parameter logic [6:0] PORT_ADDR = 7'h06) (
  input wire logic ref_clk,
  input wire logic [6:0] file_addr,
  input wire logic file_we,
  input wire logic [7:0] file_wr_data,
  output logic [7:0] file_rd_data,
  output logic port_hit,
  output logic [7:0] port_pins
);
  logic [7:0] mem [128];
  // pins differ from the latch so a latch read is caught
  assign port_pins = ~mem[PORT_ADDR];
  assign port_hit = file_addr == PORT_ADDR;
  assign file_rd_data = mem[file_addr];
  always @(posedge ref_clk)
  begin
    if (file_we)
      mem[file_addr] <= file_wr_data;
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, instr_valid = 1'h0, instr_dest = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, instr_ready, file_we, port_hit, err;
  abx_pkg::abx_op_t instr_op = abx_pkg::ABX_NOP;
  logic [7:0] instr_lit = 8'h0, file_rd_data, port_pins, file_wr_data, acc;
  logic [6:0] instr_faddr = 7'h0, file_addr;
  logic [2:0] instr_bit = 3'h0;
  logic carry_flag, digit_carry_flag, zero_flag, skip_nop;
  int error_cnt = 0, compares = 0;
  abx_execute abx_execute_i (.*);
  abx_file_mem abx_file_mem_i (.*);
  always #12.5 ref_clk = ~ref_clk;
  function logic [10:0] st;
    return {carry_flag, digit_carry_flag, zero_flag, acc};
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d = 32'h0);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task run(input abx_pkg::abx_op_t o, input logic [7:0] k, input logic [6:0] f = 7'h3,
    input logic [2:0] b = 3'h0, input logic d = 1'h0);
    instr_op <= o;
    instr_lit <= k;
    instr_faddr <= f;
    instr_bit <= b;
    instr_dest <= d;
    instr_valid <= 1'h1;
    do @(posedge ref_clk); while (instr_ready !== 1'h1);
    instr_valid <= 1'h0;
    repeat (3) @(posedge ref_clk);
  endtask
  task t_regs;
    apb(1'h0, 32'h40);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'h0, 32'h0);
    chk("acc reg", 32'h0, rd);
    apb(1'h1, 32'h0, 32'h3c);
    apb(1'h1, 32'h4, 32'h5);
    apb(1'h0, 32'h4);
    chk("status reg", 32'h5, rd);
    chk("sw state", 32'h53c, st());
    apb(1'h1, 32'h0, 32'h0);
    apb(1'h1, 32'h8, 32'h1);
  endtask
  task t_arith;
    run(abx_pkg::ABX_ADD_LITERAL_TO_ACC, 8'h8f);
    run(abx_pkg::ABX_ADD_LITERAL_TO_ACC, 8'h71);
    chk("add lit", 32'h700, st());
    run(abx_pkg::ABX_ADD_LITERAL_TO_ACC, 8'h09);
    run(abx_pkg::ABX_ADD_ACC_AND_FILE, 8'h0, 7'h3, 3'h0, 1'h1);
    chk("add file", 32'h209, st());
    @(posedge ref_clk);
    chk("file 3", 32'h17, abx_file_mem_i.mem[3]);
    run(abx_pkg::ABX_AND_ACC_WITH_FILE, 8'h0);
    chk("and file", 32'h201, st());
    run(abx_pkg::ABX_AND_LITERAL_WITH_ACC, 8'h10);
    chk("and lit", 32'h300, st());
  endtask
  task t_bits;
    run(abx_pkg::ABX_FILE_BIT_SET, 8'h0, 7'h6, 3'h7);
    @(posedge ref_clk);
    chk("port", 32'h8f, abx_file_mem_i.mem[6]);
    run(abx_pkg::ABX_FILE_BIT_CLEAR, 8'h0, 7'h3, 3'h4);
    @(posedge ref_clk);
    chk("file 3", 32'h07, abx_file_mem_i.mem[3]);
    chk("flags", 32'h300, st());
  endtask
  task t_skip;
    run(abx_pkg::ABX_TEST_BIT_SKIP_IF_ONE, 8'h0);
    run(abx_pkg::ABX_ADD_LITERAL_TO_ACC, 8'h01);
    chk("skip one", 32'h300, st());
    run(abx_pkg::ABX_TEST_BIT_SKIP_IF_ZERO, 8'h0);
    run(abx_pkg::ABX_ADD_LITERAL_TO_ACC, 8'h01);
    chk("run zero", 32'h001, st());
    run(abx_pkg::ABX_TEST_BIT_SKIP_IF_ZERO, 8'h0, 7'h3, 3'h7);
    run(abx_pkg::ABX_ADD_LITERAL_TO_ACC, 8'h01);
    chk("skip zero", 32'h001, st());
    run(abx_pkg::ABX_TEST_BIT_SKIP_IF_ONE, 8'h0, 7'h3, 3'h7);
    run(abx_pkg::ABX_ADD_LITERAL_TO_ACC, 8'h01);
    chk("run one", 32'h002, st());
  endtask
  task t_exec;
    apb(1'h0, 32'hc);
    chk("exec reg", 32'h0010_0000, rd);
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    chk("reset state", 32'h0, st());
    apb(1'h0, 32'h8);
    chk("run reset", 32'h0, rd);
    repeat (4)
    begin
      @(posedge ref_clk);
      chk("ready off", 32'h0, {31'h0, instr_ready});
    end
  endtask
  task stop_test;
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    abx_file_mem_i.mem[3] = 8'h0e;
    abx_file_mem_i.mem[6] = 8'hf0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    t_regs;
    t_arith;
    t_bits;
    t_skip;
    t_exec;
    stop_test;
  end
  initial
  begin
    #50us;
    error_cnt++;
    stop_test;
  end
endmodule
